// File: src/kds_pkg.sv
// constants, types and functional notes for the keypad and display scanner
// Functional notes
// [R1] two low scan bits step states 0..3
// [R2] state 0 drives reset and halt row
// [R3] state 1 drives continue..remote key row
// [R4] state 2 drives point..digit eight row
// [R5] state 3 drives numeric keys row
// [R6] active row plus sense line locate key
// [R7] key press interrupts cpu, cpu reads position
// [R8] key entries cross eight-bit cpu bus
// [R9] cpu writes display memory inside scanner
// [R10] display refreshes itself from memory
// [R11] four scan bits feed 1-of-16 decoder
// [R12] one digit on, pattern on groups
// [R13] ten multiplexed seven-segment digits refreshed
// [R14] ten digit drive lines, 0 to 9
// [R15] segments only with their own digit
// [R16] cpu lights key leds via segments
// [R17] two key leds from cpu ports
// [R18] scan free-runs, synchronous clear to zero
package kds_pkg;

  // system clock rate
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  // time each scan slot stays energised, in nanoseconds
  localparam int unsigned SLOT_DWELL_NS = 100_000;
  // slot dwell in clock cycles (rounded down, at least one)
  localparam int unsigned SLOT_DWELL_CYCLES =
    (SLOT_DWELL_NS / 1000) * (SYS_CLK_HZ / 1_000_000) > 0 ?
    (SLOT_DWELL_NS / 1000) * (SYS_CLK_HZ / 1_000_000) : 1;

  // widths
  localparam int unsigned SCAN_W = 4;
  localparam int unsigned ROW_W = 2;
  localparam int unsigned ROWS = 4;
  localparam int unsigned SENSE_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned DIGITS = 10;
  localparam int unsigned DWELL_W = 16;

  // key code layout: row in bits 4:3, sense line in bits 2:0
  localparam int unsigned KEY_COL_LSB = 0;
  localparam int unsigned KEY_ROW_LSB = 3;

  // keyboard row numbers
  localparam logic [1:0] ROW_RESET_HALT = 2'h0;
  localparam logic [1:0] ROW_FUNCTION = 2'h1;
  localparam logic [1:0] ROW_EDIT = 2'h2;
  localparam logic [1:0] ROW_NUMERIC = 2'h3;

  // values after reset
  localparam logic [3:0] SCAN_RESET = 4'h0;
  localparam logic [7:0] SHOW_KEY_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [15:0] DWELL_RESET = 16'h0000;

  // host read sequencer states, gray along idle-read-drain
  typedef enum logic [1:0] {
    KDS_H_IDLE = 2'b00,
    KDS_H_READ = 2'b01,
    KDS_H_DRAIN = 2'b11
  } kds_host_state_t;

endpackage

// File: src/kds_bus_if.sv
// interface joining the scanner and the host cpu
`timescale 1ns/10ps
`default_nettype none
interface kds_bus_if;
  logic key_irq; // key waiting, level
  logic key_rd; // cpu read of key position, one-cycle pulse
  logic [7:0] cpu_data_lines; // key position towards the cpu
  logic show_key_wr; // display memory write strobe
  logic [3:0] show_key_addr; // digit being written
  logic [7:0] show_key_data; // segment pattern being written
  logic scan_clr; // synchronous return of the scan to state zero

  modport scanner (
    output key_irq,
    output cpu_data_lines,
    input key_rd,
    input show_key_wr,
    input show_key_addr,
    input show_key_data,
    input scan_clr
  );

  modport cpu (
    input key_irq,
    input cpu_data_lines,
    output key_rd,
    output show_key_wr,
    output show_key_addr,
    output show_key_data,
    output scan_clr
  );
endinterface
`default_nettype wire

// File: src/kds_onehot_dec.sv
// binary to one-hot decoder with enable
`timescale 1ns/10ps
`default_nettype none
module kds_onehot_dec #(
  parameter int unsigned IN_W = 2
) (
  input wire logic [IN_W-1:0] code,
  input wire logic en,
  output logic [(1 << IN_W)-1:0] lines
);

  // exactly one line high while enabled, none otherwise
  always_comb begin
    lines = '0;
    if (en) begin
      lines[code] = 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: src/kds_scanner.sv
// keyboard and display scanner, the device end
`timescale 1ns/10ps
`default_nettype none
module kds_scanner #(
  parameter int unsigned DWELL_CYCLES = kds_pkg::SLOT_DWELL_CYCLES,
  parameter int unsigned NUM_DIGITS = kds_pkg::DIGITS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  kds_bus_if.scanner bus,
  input wire logic [7:0] key_sense_inputs,
  output logic [3:0] scan_line_bus,
  output logic [3:0] key_row_lines,
  output logic [9:0] digit_drive_lines,
  output logic [3:0] segment_group_low,
  output logic [3:0] segment_group_high
);

  // dwell counter end value, cut to counter width
  localparam logic [15:0] DWELL_LAST = 16'(DWELL_CYCLES - 1);

  // synchroniser stages for the sense pins
  logic [7:0] sense_meta_q;
  logic [7:0] sense_sync_q;

  // slot timing and scan position
  logic [15:0] dwell_q;
  logic slot_end;
  logic [3:0] scan_q;

  // decoded rows and digits, before the output registers
  logic [3:0] row_dec;
  logic [15:0] digit_dec;
  logic digit_valid;

  // last sense pattern seen on each row, for edge detection
  logic [7:0] prev_q [kds_pkg::ROWS];
  logic [7:0] new_press;

  // lowest newly pressed sense line
  logic hit;
  logic [2:0] hit_col;

  // pending key report
  logic key_pend_q;
  logic [7:0] key_code_q;
  logic accept_new;

  // display memory, one pattern per digit
  logic [7:0] show_key_mem_q [NUM_DIGITS];
  logic [7:0] cur_pattern;

  // output registers
  logic [3:0] row_q;
  logic [9:0] digit_q;
  logic [7:0] seg_q;

  // sense pins come from the keyboard, outside the clock domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_meta_q <= '0;
      sense_sync_q <= '0;
    end else begin
      sense_meta_q <= key_sense_inputs;
      sense_sync_q <= sense_meta_q;
    end
  end

  // slot end marks the last cycle that the current scan state is held
  assign slot_end = (dwell_q == DWELL_LAST);

  // dwell counter restarts with every slot and on a scan clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_q <= kds_pkg::DWELL_RESET;
    end else if (bus.scan_clr || slot_end) begin // R18
      dwell_q <= kds_pkg::DWELL_RESET;
    end else begin
      dwell_q <= dwell_q + 16'h0001;
    end
  end

  // scan state free-runs through all sixteen codes and wraps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_q <= kds_pkg::SCAN_RESET;
    end else if (bus.scan_clr) begin // R18
      scan_q <= kds_pkg::SCAN_RESET;
    end else if (slot_end) begin
      scan_q <= scan_q + 4'h1; // R1
    end
  end

  // low two scan bits select one keyboard row every slot
  kds_onehot_dec #(
    .IN_W(kds_pkg::ROW_W)
  ) u_row_dec (
    .code(scan_q[1:0]), // R1
    .en(1'b1),
    .lines(row_dec)
  );

  // codes ten to fifteen light no digit, giving a short blank gap
  assign digit_valid = ({28'h0000000, scan_q} < NUM_DIGITS);

  // all four scan bits pick one of sixteen digit selects
  kds_onehot_dec #(
    .IN_W(kds_pkg::SCAN_W)
  ) u_digit_dec (
    .code(scan_q), // R11
    .en(digit_valid),
    .lines(digit_dec)
  );

  // pattern for the digit now selected; blank outside the ten digits
  always_comb begin
    cur_pattern = kds_pkg::SHOW_KEY_RESET;
    if (digit_valid) begin
      cur_pattern = show_key_mem_q[scan_q]; // R10
    end
  end

  // row, digit and segments are registered from the same scan value,
  // so a pattern never shows under a neighbouring digit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= '0;
      digit_q <= '0;
      seg_q <= kds_pkg::SHOW_KEY_RESET;
    end else begin
      row_q <= row_dec; // R2 R3 R4 R5
      digit_q <= digit_dec[9:0]; // R12 R13 R14
      seg_q <= cur_pattern; // R15
    end
  end

  // row 0 serves reset and halt, 1 the function keys,
  // 2 the edit keys and 3 the numeric keys
  assign key_row_lines = row_q;
  assign scan_line_bus = scan_q;
  assign digit_drive_lines = digit_q;
  // low nibble on group low, high nibble on group high
  assign segment_group_low = seg_q[3:0]; // R12
  assign segment_group_high = seg_q[7:4]; // R12

  // a key counts once, on the first slot its sense line is seen high;
  // holding it down does not repeat
  assign new_press = sense_sync_q & ~prev_q[scan_q[1:0]]; // R6

  // lowest sense line wins when several rise together
  always_comb begin
    hit = 1'b0;
    hit_col = 3'h0;
    for (int i = kds_pkg::SENSE_W - 1; i >= 0; i--) begin
      if (new_press[i]) begin
        hit = 1'b1;
        hit_col = 3'(i);
      end
    end
  end

  // sense history per row, sampled at the end of its slot, when the
  // row has been energised long enough to pass the synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int r = 0; r < kds_pkg::ROWS; r++) begin
        prev_q[r] <= '0;
      end
    end else if (slot_end) begin
      prev_q[scan_q[1:0]] <= sense_sync_q; // R6
    end
  end

  // a new key is taken when none waits, or when the waiting one is read
  // in this very cycle; a press while a key waits unread is dropped
  assign accept_new = slot_end && hit && (!key_pend_q || bus.key_rd);

  // key pending flag: the new press wins over the clearing read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_pend_q <= 1'b0;
    end else if (accept_new) begin
      key_pend_q <= 1'b1; // R7
    end else if (bus.key_rd) begin
      key_pend_q <= 1'b0; // R7
    end
  end

  // key position: row in bits 4:3, sense line in bits 2:0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_code_q <= kds_pkg::KEY_RESET;
    end else if (accept_new) begin
      key_code_q <= kds_pkg::KEY_RESET;
      key_code_q[kds_pkg::KEY_ROW_LSB +: kds_pkg::ROW_W] <= scan_q[1:0]; // R6
      key_code_q[kds_pkg::KEY_COL_LSB +: 3] <= hit_col; // R6
    end
  end

  // interrupt level and key position towards the cpu
  assign bus.key_irq = key_pend_q; // R7
  assign bus.cpu_data_lines = key_code_q; // R8

  // display memory write; addresses past the last digit are ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int d = 0; d < NUM_DIGITS; d++) begin
        show_key_mem_q[d] <= kds_pkg::SHOW_KEY_RESET;
      end
    end else if (bus.show_key_wr && ({28'h0000000, bus.show_key_addr} < NUM_DIGITS)) begin
      show_key_mem_q[bus.show_key_addr] <= bus.show_key_data; // R9
    end
  end

endmodule
`default_nettype wire

// File: src/kds_host.sv
// host cpu end: takes key reports and writes display memory
`timescale 1ns/10ps
`default_nettype none
module kds_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  kds_bus_if.cpu bus,
  input wire logic wr_req,
  input wire logic [3:0] wr_digit,
  input wire logic [7:0] wr_pattern,
  input wire logic restart_scan,
  input wire logic self_test_led_req,
  input wire logic remote_led_req,
  output logic key_valid,
  output logic [7:0] key_code,
  output logic self_test_led,
  output logic remote_led
);

  // read sequencer state
  kds_pkg::kds_host_state_t state_q;
  // registered bus requests
  logic wr_q;
  logic [3:0] addr_q;
  logic [7:0] data_q;
  logic clr_q;
  // captured key report
  logic valid_q;
  logic [7:0] code_q;

  // idle sees the interrupt, read pulses the strobe and takes the data,
  // drain gives the scanner one cycle to drop its level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= kds_pkg::KDS_H_IDLE;
    end else begin
      unique case (state_q)
        kds_pkg::KDS_H_IDLE: begin
          if (bus.key_irq) begin
            state_q <= kds_pkg::KDS_H_READ; // R7
          end
        end
        kds_pkg::KDS_H_READ: begin
          state_q <= kds_pkg::KDS_H_DRAIN;
        end
        kds_pkg::KDS_H_DRAIN: begin
          state_q <= kds_pkg::KDS_H_IDLE;
        end
        default: begin
          state_q <= kds_pkg::KDS_H_IDLE;
        end
      endcase
    end
  end

  // read strobe is a handshake output, straight from the state
  assign bus.key_rd = (state_q == kds_pkg::KDS_H_READ); // R7

  // key position captured on the edge that takes the read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      code_q <= kds_pkg::KEY_RESET;
    end else begin
      valid_q <= (state_q == kds_pkg::KDS_H_READ);
      if (state_q == kds_pkg::KDS_H_READ) begin
        code_q <= bus.cpu_data_lines; // R8
      end
    end
  end

  // display writes and scan clear go out one cycle after the request;
  // key leds are just digit patterns with the wanted bits set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      addr_q <= '0;
      data_q <= kds_pkg::SHOW_KEY_RESET;
      clr_q <= 1'b0;
    end else begin
      wr_q <= wr_req; // R9 R16
      addr_q <= wr_digit;
      data_q <= wr_pattern;
      clr_q <= restart_scan; // R18
    end
  end

  // the two key leds outside the scan come from plain output ports
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      self_test_led <= 1'b0;
      remote_led <= 1'b0;
    end else begin
      self_test_led <= self_test_led_req; // R17
      remote_led <= remote_led_req; // R17
    end
  end

  assign bus.show_key_wr = wr_q;
  assign bus.show_key_addr = addr_q;
  assign bus.show_key_data = data_q;
  assign bus.scan_clr = clr_q;
  assign key_valid = valid_q;
  assign key_code = code_q;

endmodule
`default_nettype wire

// File: verification/kds_bus_checker.sv
// concurrent checks on the bus between scanner and host
`timescale 1ns/10ps
`default_nettype none
module kds_bus_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic key_irq,
  input wire logic key_rd,
  input wire logic [7:0] cpu_data_lines,
  input wire logic show_key_wr,
  input wire logic scan_clr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // a read only ever answers a pending key
  a_rd_needs_irq: assert property (key_rd |-> key_irq)
    else $error("key read without pending key");
  // the read strobe is a single pulse
  a_rd_single_pulse: assert property (key_rd |=> !key_rd)
    else $error("key read strobe longer than one cycle");
  // host answers a new key within two cycles
  a_irq_served: assert property ($rose(key_irq) |-> ##[1:2] key_rd)
    else $error("pending key not read in time");
  // the read takes the pending key away
  a_rd_clears_irq: assert property (key_rd |=> !key_irq)
    else $error("key request stayed up after read");
  // an unread key stays pending
  a_irq_holds: assert property (key_irq && !key_rd |=> key_irq)
    else $error("pending key lost before read");
  // position must not move while the cpu may read it
  a_code_stable: assert property (key_irq && !key_rd |=> $stable(cpu_data_lines))
    else $error("key position changed while pending");
  // only row and sense line bits carry the position
  a_code_upper_zero: assert property (key_irq |-> cpu_data_lines[7:5] == 3'h0)
    else $error("key position upper bits not zero");
  // presses are taken at slot ends only, so requests are spaced out
  a_irq_gap: assert property ($fell(key_irq) |-> !key_irq [*4])
    else $error("key requests closer than one slot");

  c_key_read: cover property (key_rd);
  c_show_key_write: cover property (show_key_wr ##1 show_key_wr);
  c_scan_clear: cover property (scan_clr ##1 !scan_clr);
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench: scanner and host joined back to back
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int unsigned DW = 8; // short slot keeps a frame at 128 cycles
  logic sys_clk, rst_n, wr_req, restart_scan, st_req, rm_req, key_on;
  logic [3:0] wr_digit, scan_line_bus, key_row_lines, seg_lo, seg_hi;
  logic [7:0] wr_pattern, key_mask, key_code, lfsr_q;
  logic [9:0] digit_drive_lines;
  logic [1:0] key_r; // row the pressed key sits on
  logic key_valid, self_test_led, remote_led;
  logic [7:0] mem [10]; // expected display memory
  int n_fail, n_checks, n_cyc, hits;
  kds_bus_if bus ();
  // key matrix: the sense lines follow the energised row only
  wire logic [7:0] sense = (key_on && key_row_lines[key_r]) ? key_mask : 8'h00;

  kds_scanner #(.DWELL_CYCLES(DW), .NUM_DIGITS(10)) kds_scanner_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus), .key_sense_inputs(sense), .scan_line_bus(scan_line_bus), .key_row_lines(key_row_lines),
    .digit_drive_lines(digit_drive_lines), .segment_group_low(seg_lo), .segment_group_high(seg_hi));
  kds_host kds_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .wr_req(wr_req), .wr_digit(wr_digit),
    .wr_pattern(wr_pattern), .restart_scan(restart_scan), .self_test_led_req(st_req), .remote_led_req(rm_req),
    .key_valid(key_valid), .key_code(key_code), .self_test_led(self_test_led), .remote_led(remote_led));
  kds_bus_checker kds_bus_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n), .key_irq(bus.key_irq),
    .key_rd(bus.key_rd), .cpu_data_lines(bus.cpu_data_lines), .show_key_wr(bus.show_key_wr), .scan_clr(bus.scan_clr));

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // several keys on one row: the lowest sense line wins
  function automatic logic [2:0] low_bit(input logic [7:0] m);
    low_bit = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (m[i])
        low_bit = 3'(i);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // every drive and sample lands 5 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // follow the scan: order, dwell, row, digit and segments lag it by one
  task automatic watch(input int n);
    logic [3:0] prev;
    int dw;
    prev = scan_line_bus;
    dw = 0;
    repeat (n) begin
      step(1);
      dw++;
      chk(16'(key_row_lines), 16'(4'h1 << prev[1:0]));
      chk(16'(digit_drive_lines), prev < 4'hA ? 16'(10'h001 << prev) : 16'h0000);
      if (prev < 4'hA)
        chk({8'h00, seg_hi, seg_lo}, {8'h00, mem[prev]});
      else
        chk({8'h00, seg_hi, seg_lo}, 16'h0000);
      if (scan_line_bus !== prev) begin
        chk(16'(scan_line_bus), 16'(4'(prev + 4'h1)));
        chk(16'(dw), 16'(DW));
        dw = 0;
      end
      prev = scan_line_bus;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // cut a hang short; the planned run is near 2180 cycles
  always @(posedge sys_clk) begin
    n_cyc++;
    if (n_cyc == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n, wr_req, restart_scan, st_req, rm_req, key_on} = 6'h00;
    wr_digit = 4'h0;
    wr_pattern = 8'h00;
    key_r = 2'h0;
    key_mask = 8'h00;
    lfsr_q = 8'h57;
    repeat (10) @(posedge sys_clk);
    #5;
    chk(16'(digit_drive_lines), 16'h0000);
    rst_n = 1'b1;
    step(2);
    // back-to-back writes to every address; 10..15 must touch nothing
    wr_req = 1'b1;
    for (int d = 0; d < 16; d++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr_digit = 4'(d);
      wr_pattern = (d == 9) ? 8'hFF : lfsr_q;
      if (d < 10)
        mem[d] = wr_pattern;
      step(1);
    end
    wr_req = 1'b0;
    step(3);
    // restart the scan, then watch three whole frames from slot zero
    restart_scan = 1'b1;
    step(1);
    restart_scan = 1'b0;
    step(1);
    chk(16'(scan_line_bus), 16'h0000);
    watch(384);
    // one key per row, held for 300 cycles, just over two frames: reported exactly once
    for (int r = 0; r < 4; r++) begin
      lfsr_q = lfsr_next(lfsr_q);
      key_r = 2'(r);
      key_mask = (r == 0) ? 8'h80 : lfsr_q;
      st_req = lfsr_q[0];
      rm_req = lfsr_q[1];
      key_on = 1'b1;
      hits = 0;
      repeat (300) begin
        step(1);
        if (key_valid === 1'b1) begin
          hits++;
          chk(16'(key_code), 16'({3'h0, key_r, low_bit(key_mask)}));
        end
      end
      chk(16'(hits), 16'h0001);
      chk({14'h0000, self_test_led, remote_led}, {14'h0000, st_req, rm_req});
      key_on = 1'b0;
      step(140);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
